// ===== memory_type_range_lookup.sv
// Purpose: Resolves memory types of addresses and ranges from range registers.
// Assumes: Register strobes are one cycle and never both at once.
// Notes:   Lookup answers one cycle after the request; queries walk one granule a cycle.

`timescale 1ns/1ps

// Summary of operation
// [RL1] Reset clears pair valid and global enable.
// [RL2] Software zeroes all range fields first.
// [RL3] Global enable clear gives uncacheable everywhere.
// [RL4] Fixed ranges need capability and enable.
// [RL5] Fixed bands: 64K, 16K, 4K regions.
// [RL6] Invalid pairs never match.
// [RL7] Masked address equals masked base means match.
// [RL8] Examine exactly the reported pair count.
// [RL9] No match yields the default type.
// [RL10] Overlaps: same passes, UC wins, WT+WB gives WT.
// [RL11] Query aligns range, checks each 4K granule.
// [RL12] Query wrapping 4 GByte returns invalid.
// [RL13] Differing granule types give mixed result.
// [RL14] No range support: requests return unsupported.
// [RL15] Update needs aligned nonzero range, valid type.
// [RL16] Fixed-fitting update writes fixed registers.
// [RL17] Variable update reports its specific failures.
// [RL18] Updater disables, flushes, then clears enable.
// [RL19] Updater flushes TLBs via page controls.
// [RL20] Updater re-enables, flushes again, restores state.
// [RL21] Updater may batch several range changes.
// [RL22] Remapping never weakens ordering.
// [RL23] Lookup latency fixed; writes seen afterwards.
module memory_type_range_lookup
#(
	parameter int   NUM_PAIRS        = 8,
	parameter logic FIX_SUPPORTED    = 1'b1,
	parameter logic WC_SUPPORTED     = 1'b1,
	parameter logic RANGES_SUPPORTED = 1'b1
)
(
	input  wire logic        sys_clk,
	input  wire logic        srst,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic [31:0]      reg_rdata,
	input  wire logic        lookup_req,
	input  wire logic [31:0] lookup_addr,
	output logic             lookup_valid,
	output logic [2:0]       lookup_type
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed
	{
		logic [2:0]                       def_type;
		logic                             fixed_range_enable;
		logic                             global_enable;
		logic [NUM_PAIRS-1:0][19:0]       vbase;
		logic [NUM_PAIRS-1:0][2:0]        vtype;
		logic [NUM_PAIRS-1:0][19:0]       vmask;
		logic [NUM_PAIRS-1:0]             vvalid;
		logic [range_type_pkg::FIXED_REGIONS-1:0][2:0] ftype;
		logic [31:0]                      q_base;
		logic [31:0]                      q_size;
		range_type_pkg::query_state_t     q_state;
		logic [19:0]                      q_cur;
		logic [19:0]                      q_last;
		logic [2:0]                       q_first;
		logic [2:0]                       q_status;
		logic [2:0]                       q_type;
		logic                             lookup_valid;
		logic [2:0]                       lookup_type;
		logic [31:0]                      rdata;
	} state_t;

	state_t cur;
	state_t next_cur;

	logic [NUM_PAIRS-1:0] lk_hit;
	logic [NUM_PAIRS-1:0] q_hit;
	logic                 lk_in_fixed;
	logic                 q_in_fixed;
	logic [6:0]           lk_region;
	logic [6:0]           q_region;
	logic [2:0]           lk_type;
	logic [2:0]           g_type;
	logic [2:0]           def_remap;
	logic                 lk_fixed_path;

	// ------------------------------------------------------------
	// Matchers: one set for lookups, one for the query walker
	// ------------------------------------------------------------
	// Only the reported pair count is instantiated and examined.
	for (genvar g = 0; g < NUM_PAIRS; g++)
	begin : g_pairs
		variable_pair_match u_lk
		(
			.valid   (cur.vvalid[g]),
			.granule (lookup_addr[31:12]),
			.base    (cur.vbase[g]),
			.mask    (cur.vmask[g]),
			.hit     (lk_hit[g])
		); // see [RL8] see [RL6] see [RL7]
		variable_pair_match u_q
		(
			.valid   (cur.vvalid[g]),
			.granule (cur.q_cur),
			.base    (cur.vbase[g]),
			.mask    (cur.vmask[g]),
			.hit     (q_hit[g])
		);
	end

	fixed_range_index u_lk_fix
	(
		.granule  (lookup_addr[31:12]),
		.in_fixed (lk_in_fixed),
		.region   (lk_region)
	); // see [RL5]

	fixed_range_index u_q_fix
	(
		.granule  (cur.q_cur),
		.in_fixed (q_in_fixed),
		.region   (q_region)
	);

	// ------------------------------------------------------------
	// Type resolution
	// ------------------------------------------------------------
	// Undefined overlaps fall to uncacheable; that is the safe choice.
	function automatic logic [2:0] resolve(input logic use_fixed, input logic [2:0] ft,
		input logic [NUM_PAIRS-1:0] hit, input logic [NUM_PAIRS-1:0][2:0] vt,
		input logic [2:0] dt, input logic en);
		logic [2:0] acc;
		logic       any;
		acc = dt; // see [RL9]
		any = 1'b0;
		for (int i = 0; i < NUM_PAIRS; i++)
		begin
			if (hit[i])
			begin
				if (!any || acc == vt[i])
					acc = vt[i];
				else if ((acc == range_type_pkg::WRITE_THROUGH_TYPE &&
					vt[i] == range_type_pkg::WRITE_BACK_TYPE) ||
					(acc == range_type_pkg::WRITE_BACK_TYPE &&
					vt[i] == range_type_pkg::WRITE_THROUGH_TYPE))
					acc = range_type_pkg::WRITE_THROUGH_TYPE; // see [RL10]
				else
					acc = range_type_pkg::UNCACHEABLE_TYPE; // see [RL10]
				any = 1'b1;
			end
		end
		if (use_fixed)
			acc = ft;
		if (!en)
			acc = range_type_pkg::UNCACHEABLE_TYPE; // see [RL3]
		return range_type_pkg::remap_type(acc, WC_SUPPORTED); // see [RL22]
	endfunction : resolve

	// Fixed ranges only when supported and enabled.
	assign lk_fixed_path = FIX_SUPPORTED && cur.fixed_range_enable && lk_in_fixed; // see [RL4]
	assign lk_type = resolve(lk_fixed_path, cur.ftype[lk_region], lk_hit, cur.vtype,
		cur.def_type, cur.global_enable);
	assign g_type = resolve(FIX_SUPPORTED && cur.fixed_range_enable && q_in_fixed,
		cur.ftype[q_region], q_hit, cur.vtype, cur.def_type, cur.global_enable);
	assign def_remap = range_type_pkg::remap_type(cur.def_type, WC_SUPPORTED);

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb
	begin
		logic [32:0] q_end;
		logic [31:0] q_lastb;
		logic [2:0]  ck_type;
		next_cur = cur;
		q_end = {1'b0, cur.q_base & 32'hFFFF_F000} + {1'b0, cur.q_size};
		q_lastb = q_end[31:0] - 32'h0000_0001;
		ck_type = reg_wdata[range_type_pkg::CTRL_TYPE_LSB +: 3];

		// Lookup answers a fixed one cycle later from the current registers.
		next_cur.lookup_valid = lookup_req; // see [RL23]
		if (lookup_req)
			next_cur.lookup_type = lk_type;

		// Register writes.
		if (reg_wr)
		begin
			case (reg_addr)
				range_type_pkg::DEFAULT_TYPE_CONFIG_ADDR:
				begin
					next_cur.def_type = reg_wdata[range_type_pkg::TYPE_LSB +: 3];
					next_cur.fixed_range_enable = reg_wdata[range_type_pkg::FIXED_ENABLE_BIT];
					next_cur.global_enable = reg_wdata[range_type_pkg::GLOBAL_ENABLE_BIT];
				end
				range_type_pkg::QUERY_BASE_ADDR: next_cur.q_base = reg_wdata;
				range_type_pkg::QUERY_SIZE_ADDR: next_cur.q_size = reg_wdata;
				default: next_cur.rdata = cur.rdata;
			endcase
			for (int i = 0; i < NUM_PAIRS; i++)
			begin
				if (reg_addr == range_type_pkg::VARIABLE_RANGE_ADDR + 8'(2 * i))
				begin
					next_cur.vtype[i] = reg_wdata[range_type_pkg::TYPE_LSB +: 3];
					next_cur.vbase[i] = reg_wdata[31:range_type_pkg::GRANULE_LSB];
				end
				if (reg_addr == range_type_pkg::VARIABLE_RANGE_ADDR + 8'(2 * i + 1))
				begin
					next_cur.vvalid[i] = reg_wdata[range_type_pkg::PAIR_VALID_BIT];
					next_cur.vmask[i] = reg_wdata[31:range_type_pkg::GRANULE_LSB];
				end
			end
			for (int k = 0; k < range_type_pkg::FIXED_WORDS; k++)
			begin
				if (reg_addr == range_type_pkg::FIXED_RANGE_TYPES_ADDR + 8'(k))
				begin
					for (int j = 0; j < range_type_pkg::FIXED_FIELDS_PER_WORD; j++)
						next_cur.ftype[4 * k + j] = reg_wdata[8 * j +: 3];
				end
			end
		end

		// Query sequencer: start, then one granule per cycle.
		case (cur.q_state)
			range_type_pkg::Q_IDLE:
			begin
				if (reg_wr && reg_addr == range_type_pkg::QUERY_CONTROL_ADDR)
				begin
					next_cur.q_type = range_type_pkg::UNCACHEABLE_TYPE;
					if (!RANGES_SUPPORTED)
						next_cur.q_status = range_type_pkg::STATUS_UNSUPPORTED; // see [RL14]
					else if (reg_wdata[range_type_pkg::CTRL_CHECK_BIT])
					begin
						// Update request check; the update itself is done by software.
						if (cur.q_base[11:0] != 12'h000 || cur.q_size[11:0] != 12'h000 ||
							cur.q_size == 32'h0000_0000 || q_end > 33'h1_0000_0000)
							next_cur.q_status = range_type_pkg::STATUS_INVALID;
						else if (range_type_pkg::remap_type(ck_type, WC_SUPPORTED) != ck_type)
							next_cur.q_status = range_type_pkg::STATUS_UNSUPPORTED;
						else
							next_cur.q_status = range_type_pkg::STATUS_OK;
					end
					else if (reg_wdata[range_type_pkg::CTRL_QUERY_BIT])
					begin
						if (cur.q_size == 32'h0000_0000 || q_end > 33'h1_0000_0000)
							next_cur.q_status = range_type_pkg::STATUS_INVALID; // see [RL12]
						else if (!cur.global_enable)
							next_cur.q_status = range_type_pkg::STATUS_OK; // see [RL3]
						else
						begin
							// Base rounds down; the end is the rounded base plus size, with a partial last granule included.
							next_cur.q_cur = cur.q_base[31:12]; // see [RL11]
							next_cur.q_last = q_lastb[31:12];
							next_cur.q_status = range_type_pkg::STATUS_BUSY;
							next_cur.q_state = range_type_pkg::Q_FIRST;
						end
					end
				end
			end
			range_type_pkg::Q_FIRST:
			begin
				next_cur.q_first = g_type;
				next_cur.q_type = g_type;
				if (cur.q_cur == cur.q_last)
				begin
					next_cur.q_status = range_type_pkg::STATUS_OK;
					next_cur.q_state = range_type_pkg::Q_IDLE;
				end
				else
				begin
					next_cur.q_cur = cur.q_cur + 20'h00001;
					next_cur.q_state = range_type_pkg::Q_WALK;
				end
			end
			range_type_pkg::Q_WALK:
			begin
				if (g_type != cur.q_first)
				begin
					next_cur.q_status = range_type_pkg::MULTIPLE_TYPE_RESULT; // see [RL13]
					next_cur.q_state = range_type_pkg::Q_IDLE;
				end
				else if (cur.q_cur == cur.q_last)
				begin
					next_cur.q_status = range_type_pkg::STATUS_OK;
					next_cur.q_state = range_type_pkg::Q_IDLE;
				end
				else
					next_cur.q_cur = cur.q_cur + 20'h00001; // see [RL11]
			end
			default: next_cur.q_state = range_type_pkg::Q_IDLE;
		endcase

		// Read data stands only in the cycle after the strobe; unmapped reads give zero.
		next_cur.rdata = 32'h0000_0000;
		if (reg_rd)
		begin
			case (reg_addr)
				range_type_pkg::DEFAULT_TYPE_CONFIG_ADDR:
					next_cur.rdata = {20'h00000, cur.global_enable, cur.fixed_range_enable,
						7'h00, cur.def_type};
				range_type_pkg::RANGE_CAPABILITY_ADDR:
					next_cur.rdata = {21'h000000, WC_SUPPORTED, 1'b0, FIX_SUPPORTED,
						8'(NUM_PAIRS)};
				range_type_pkg::QUERY_BASE_ADDR: next_cur.rdata = cur.q_base;
				range_type_pkg::QUERY_SIZE_ADDR: next_cur.rdata = cur.q_size;
				range_type_pkg::QUERY_CONTROL_ADDR:
					next_cur.rdata = {21'h000000, cur.q_type, 5'h00, cur.q_status};
				default: next_cur.rdata = 32'h0000_0000;
			endcase
			for (int i = 0; i < NUM_PAIRS; i++)
			begin
				if (reg_addr == range_type_pkg::VARIABLE_RANGE_ADDR + 8'(2 * i))
					next_cur.rdata = {cur.vbase[i], 9'h000, cur.vtype[i]};
				if (reg_addr == range_type_pkg::VARIABLE_RANGE_ADDR + 8'(2 * i + 1))
					next_cur.rdata = {cur.vmask[i], cur.vvalid[i], 11'h000};
			end
			for (int k = 0; k < range_type_pkg::FIXED_WORDS; k++)
			begin
				if (reg_addr == range_type_pkg::FIXED_RANGE_TYPES_ADDR + 8'(k))
				begin
					for (int j = 0; j < range_type_pkg::FIXED_FIELDS_PER_WORD; j++)
						next_cur.rdata[8 * j +: 3] = cur.ftype[4 * k + j];
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	// Everything clears, which also gives software the zeroed start it expects.
	always_ff @(posedge sys_clk)
	begin
		if (srst)
			cur <= '0; // see [RL1]
		else
			cur <= next_cur; // see [RL23]
	end

	assign reg_rdata    = cur.rdata;
	assign lookup_valid = cur.lookup_valid;
	assign lookup_type  = cur.lookup_type;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	reset_clears_a: assert property (@(posedge sys_clk) srst |=> // see [RL1]
		(!cur.global_enable && cur.vvalid == '0 && !lookup_valid))
		else $error("Reset left a range enabled.");

	disabled_uc_a: assert property (@(posedge sys_clk) disable iff (srst) // see [RL3]
		lookup_req && !cur.global_enable |=>
		lookup_type == range_type_pkg::UNCACHEABLE_TYPE)
		else $error("Disabled unit returned a cacheable type.");

	lookup_latency_a: assert property (@(posedge sys_clk) disable iff (srst) // see [RL23]
		lookup_req |=> lookup_valid ##1 (lookup_valid == $past(lookup_req)))
		else $error("Lookup answer not one cycle after request.");

	fixed_hit_a: assert property (@(posedge sys_clk) disable iff (srst) // see [RL5]
		lookup_req && cur.global_enable && lk_fixed_path |=>
		lookup_type == range_type_pkg::remap_type($past(cur.ftype[lk_region]), WC_SUPPORTED))
		else $error("Fixed region type not returned.");

	default_type_a: assert property (@(posedge sys_clk) disable iff (srst) // see [RL9]
		lookup_req && cur.global_enable && !lk_fixed_path && lk_hit == '0 |=>
		lookup_type == $past(def_remap))
		else $error("Unmatched address missed default type.");

	invalid_pair_a: assert property (@(posedge sys_clk) disable iff (srst) // see [RL6]
		(lk_hit & ~cur.vvalid) == '0)
		else $error("Invalid pair produced a match.");

	uc_wins_a: assert property (@(posedge sys_clk) disable iff (srst) // see [RL10]
		lookup_req && cur.global_enable && !lk_fixed_path && lk_hit[0] &&
		cur.vtype[0] == range_type_pkg::UNCACHEABLE_TYPE |=>
		lookup_type == range_type_pkg::UNCACHEABLE_TYPE)
		else $error("Uncacheable overlap did not win.");

	wrap_invalid_a: assert property (@(posedge sys_clk) disable iff (srst) // see [RL12]
		RANGES_SUPPORTED && cur.q_state == range_type_pkg::Q_IDLE && reg_wr &&
		reg_addr == range_type_pkg::QUERY_CONTROL_ADDR && reg_wdata[1:0] == 2'b01 &&
		({1'b0, cur.q_base & 32'hFFFF_F000} + {1'b0, cur.q_size}) > 33'h1_0000_0000 |=>
		cur.q_status == range_type_pkg::STATUS_INVALID)
		else $error("Wrapping query not flagged invalid.");

	no_support_a: assert property (@(posedge sys_clk) disable iff (srst) // see [RL14]
		!RANGES_SUPPORTED && cur.q_state == range_type_pkg::Q_IDLE && reg_wr &&
		reg_addr == range_type_pkg::QUERY_CONTROL_ADDR |=>
		cur.q_status == range_type_pkg::STATUS_UNSUPPORTED)
		else $error("Unsupported status missing.");

	remap_safe_a: assert property (@(posedge sys_clk) disable iff (srst) // see [RL22]
		lookup_valid && !WC_SUPPORTED |->
		lookup_type != range_type_pkg::WRITE_COMBINING_TYPE)
		else $error("Unsupported write-combining type returned.");

endmodule : memory_type_range_lookup

// ===== range_type_pkg.sv
// Purpose: Shared constants and types for the memory-type range unit.
// Assumes: 32-bit physical addresses, 4-KByte granules, 8-bit register index port.
// Notes:   Register offsets are word indices on the plain register port.

package range_type_pkg;

	// ------------------------------------------------------------
	// Memory type encodings
	// ------------------------------------------------------------
	localparam logic [2:0] UNCACHEABLE_TYPE     = 3'h0;
	localparam logic [2:0] WRITE_COMBINING_TYPE = 3'h1;
	localparam logic [2:0] WRITE_THROUGH_TYPE   = 3'h4;
	localparam logic [2:0] WRITE_PROTECTED_TYPE = 3'h5;
	localparam logic [2:0] WRITE_BACK_TYPE      = 3'h6;

	// ------------------------------------------------------------
	// Register indices
	// ------------------------------------------------------------
	localparam logic [7:0] DEFAULT_TYPE_CONFIG_ADDR = 8'h00;
	localparam logic [7:0] RANGE_CAPABILITY_ADDR    = 8'h01;
	localparam logic [7:0] QUERY_BASE_ADDR          = 8'h02;
	localparam logic [7:0] QUERY_SIZE_ADDR          = 8'h03;
	localparam logic [7:0] QUERY_CONTROL_ADDR       = 8'h04;
	localparam logic [7:0] VARIABLE_RANGE_ADDR      = 8'h10;
	localparam logic [7:0] FIXED_RANGE_TYPES_ADDR   = 8'h40;
	localparam int         FIXED_WORDS              = 22;
	localparam int         FIXED_REGIONS            = 88;
	localparam int         FIXED_FIELDS_PER_WORD    = 4;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int TYPE_LSB           = 0;
	localparam int FIXED_ENABLE_BIT   = 10;
	localparam int GLOBAL_ENABLE_BIT  = 11;
	localparam int PAIR_VALID_BIT     = 11;
	localparam int GRANULE_LSB        = 12;
	localparam int CAP_FIXED_BIT      = 8;
	localparam int CAP_WC_BIT         = 10;
	localparam int CTRL_QUERY_BIT     = 0;
	localparam int CTRL_CHECK_BIT     = 1;
	localparam int CTRL_TYPE_LSB      = 4;
	localparam int STATUS_TYPE_LSB    = 8;

	// ------------------------------------------------------------
	// Fixed region index bases and timing
	// ------------------------------------------------------------
	localparam logic [6:0] FIXED_64K_BASE = 7'h00;
	localparam logic [6:0] FIXED_16K_BASE = 7'h08;
	localparam logic [6:0] FIXED_4K_BASE  = 7'h18;
	localparam int         LOOKUP_LATENCY = 1;

	// ------------------------------------------------------------
	// Query status codes and sequencer states
	// ------------------------------------------------------------
	localparam logic [2:0] STATUS_OK            = 3'h0;
	localparam logic [2:0] STATUS_BUSY          = 3'h1;
	localparam logic [2:0] STATUS_INVALID       = 3'h2;
	localparam logic [2:0] STATUS_UNSUPPORTED   = 3'h3;
	localparam logic [2:0] MULTIPLE_TYPE_RESULT = 3'h4;

	typedef enum logic [1:0]
	{
		Q_IDLE  = 2'b00,
		Q_FIRST = 2'b01,
		Q_WALK  = 2'b10
	} query_state_t;

	// Unsupported or reserved encodings fall back to uncacheable, the strongest ordering.
	function automatic logic [2:0] remap_type(input logic [2:0] t, input logic wc_ok);
		logic [2:0] r;
		r = UNCACHEABLE_TYPE;
		if ((t == WRITE_COMBINING_TYPE && wc_ok) || t == WRITE_THROUGH_TYPE ||
			t == WRITE_PROTECTED_TYPE || t == WRITE_BACK_TYPE)
		begin
			r = t;
		end
		return r;
	endfunction : remap_type

endpackage : range_type_pkg

// ===== fixed_range_index.sv
// Purpose: Maps a 4-KByte granule number to its fixed region index.
// Assumes: Granule is physical address bits 31 to 12.
// Notes:   Combinational; in_fixed is high only below 1 MByte.

`timescale 1ns/1ps

module fixed_range_index
(
	input  wire logic [19:0] granule,
	output logic             in_fixed,
	output logic [6:0]       region
);

	// Three bands: 64-KByte, 16-KByte and 4-KByte regions.
	always_comb
	begin
		in_fixed = (granule[19:8] == 12'h000);
		if (!granule[7])
			region = range_type_pkg::FIXED_64K_BASE + {4'h0, granule[6:4]};
		else if (!granule[6])
			region = range_type_pkg::FIXED_16K_BASE + {3'h0, granule[5:2]};
		else
			region = range_type_pkg::FIXED_4K_BASE + {1'b0, granule[5:0]};
	end

endmodule : fixed_range_index

// ===== variable_pair_match.sv
// Purpose: Base/mask comparison for one variable range pair.
// Assumes: All operands are 4-KByte granule numbers.
// Notes:   Discontiguous masks are compared as written.

`timescale 1ns/1ps

module variable_pair_match
(
	input  wire logic        valid,
	input  wire logic [19:0] granule,
	input  wire logic [19:0] base,
	input  wire logic [19:0] mask,
	output logic             hit
);

	// A cleared valid flag removes the pair from matching.
	assign hit = valid && ((granule & mask) == (base & mask));

endmodule : variable_pair_match

// ===== access_pipe_model.sv
// Purpose: Stand-in for the memory access pipeline that asks for memory types.
// Assumes: The bench issues one request at a time through the fetch task.
// Notes:   Idle address lines show the inverse of the last address, never a held value.

`timescale 1ns/1ps

module access_pipe_model
(
	input  wire logic        sys_clk,
	output logic             lookup_req,
	output logic [31:0]      lookup_addr,
	input  wire logic        lookup_valid,
	input  wire logic [2:0]  lookup_type
);
	// ------------------------------------------------------------
	// Request driver
	// ------------------------------------------------------------
	// Idle values at time zero, so the unit never sees an unknown request.
	initial
	begin
		lookup_req  = 1'b0;
		lookup_addr = 32'h0000_0000;
	end

	// One request; the answer is taken 1 ns after the edge that takes the request.
	task automatic fetch(input logic [31:0] a, output logic v, output logic [2:0] t);
		@(posedge sys_clk);
		lookup_req  <= 1'b1;
		lookup_addr <= a;
		@(posedge sys_clk);
		lookup_req  <= 1'b0;
		lookup_addr <= ~a; // A stale address must not pass for a live one.
		#1;
		v = lookup_valid;
		t = lookup_type;
	endtask : fetch
endmodule : access_pipe_model

// ===== tb_memory_type_range_lookup.sv
// Purpose: Self-checking bench for the memory-type range unit.
// Assumes: Default parameters: eight pairs, fixed ranges and combining supported.
// Notes:   Expected types are worked out from the range layout programmed below.

`timescale 1ns/1ps

module tb_memory_type_range_lookup;
	logic        sys_clk;
	logic        srst;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [31:0] reg_rdata;
	logic        lookup_req;
	logic [31:0] lookup_addr;
	logic        lookup_valid;
	logic [2:0]  lookup_type;
	logic [31:0] d;
	int          mismatches;
	int          checks;
	// Pair setup: address in the top byte, data below.
	// Pair 0 is the uncacheable hole, which wins over the write-back pair 1 it overlaps.
	logic [39:0] pairs [10] = '{40'h10_0050_0000, 40'h11_FFF0_0800, 40'h12_0040_0006,
		40'h13_FFC0_0800, 40'h14_0040_0004, 40'h15_FFF0_0800, 40'h16_0060_0004,
		40'h17_FFF0_0000, 40'h1E_0100_0001, 40'h1F_FFF0_0800};

	memory_type_range_lookup dut (.sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.lookup_req(lookup_req), .lookup_addr(lookup_addr), .lookup_valid(lookup_valid),
		.lookup_type(lookup_type));
	access_pipe_model pipe (.sys_clk(sys_clk), .lookup_req(lookup_req),
		.lookup_addr(lookup_addr), .lookup_valid(lookup_valid), .lookup_type(lookup_type));

	// ------------------------------------------------------------
	// Clock and watchdog
	// ------------------------------------------------------------
	// Free-running clock, 4 ns period.
	initial
	begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	// The longest walk is four granules; 20000 cycles means a hang.
	initial
	begin
		#80000;
		mismatches++;
		conclude();
	end

	// ------------------------------------------------------------
	// Bus tasks and comparison
	// ------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
			$display("mismatch at %0t: got %h expected %h", $time, seen, exp);
		if (seen !== exp)
			mismatches++;
	endtask : check

	// Write strobe stands one cycle beside address and data.
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge sys_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= v;
		@(posedge sys_clk);
		reg_wr    <= 1'b0;
	endtask : wr

	// Read data stand only in the cycle after the strobe, so sample just then.
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge sys_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd   <= 1'b0;
		#1;
		v = reg_rdata;
	endtask : rd

	task automatic lk(input logic [31:0] a, input logic [2:0] e);
		logic       v;
		logic [2:0] t;
		pipe.fetch(a, v, t);
		check({28'h0, v, t}, {28'h0, 1'b1, e});
	endtask : lk

	// Issue a query command, poll until not busy, compare the masked status.
	task automatic qry(input logic [31:0] b, input logic [31:0] s, input logic [7:0] c,
		input logic [31:0] m, input logic [31:0] e);
		logic [31:0] st;
		wr(range_type_pkg::QUERY_BASE_ADDR, b);
		wr(range_type_pkg::QUERY_SIZE_ADDR, s);
		wr(range_type_pkg::QUERY_CONTROL_ADDR, {24'h0, c});
		for (int n = 0; n < 600; n++)
		begin
			rd(range_type_pkg::QUERY_CONTROL_ADDR, st);
			if (st[2:0] !== range_type_pkg::STATUS_BUSY)
				break;
		end
		check(st & m, e);
	endtask : qry

	task automatic conclude();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : conclude

	// ------------------------------------------------------------
	// Test sequence
	// ------------------------------------------------------------
	initial
	begin
		srst = 1'b1;
		reg_addr = 8'h00;
		reg_wdata = 32'h0000_0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		repeat (4) @(posedge sys_clk);
		srst <= 1'b0;
		rd(8'h00, d); check(d, 32'h0);
		rd(8'h11, d); check(d, 32'h0);
		rd(8'h01, d); check(d, 32'h0000_0508);
		// Read data stand for one cycle only and then fall back to zero.
		@(posedge sys_clk);
		#1;
		check(reg_rdata, 32'h0);
		rd(8'h08, d); check(d, 32'h0); // Unmapped index reads zero.
		wr(8'h00, 32'h0000_0006);
		lk(32'h0040_0000, range_type_pkg::UNCACHEABLE_TYPE);
		for (int i = 0; i < 22; i++) wr(8'h40 + 8'(i), 32'h0);
		for (int i = 0; i < 16; i++) wr(8'h10 + 8'(i), 32'h0);
		wr(8'h40, 32'h0000_0104);
		wr(8'h42, 32'h0000_0005);
		wr(8'h46, 32'h0000_0004);
		wr(8'h00, 32'h0000_0C05);
		lk(32'h0000_FFFF, range_type_pkg::WRITE_THROUGH_TYPE);
		lk(32'h0001_0000, range_type_pkg::WRITE_COMBINING_TYPE);
		lk(32'h0008_0000, range_type_pkg::WRITE_PROTECTED_TYPE);
		lk(32'h0008_4000, range_type_pkg::UNCACHEABLE_TYPE);
		lk(32'h000C_0000, range_type_pkg::WRITE_THROUGH_TYPE);
		lk(32'h000C_1000, range_type_pkg::UNCACHEABLE_TYPE);
		wr(8'h00, 32'h0000_0405);
		for (int i = 0; i < 10; i++) wr(pairs[i][39:32], pairs[i][31:0]);
		wr(8'h00, 32'h0000_0C05);
		lk(32'h0060_0000, range_type_pkg::WRITE_BACK_TYPE);
		lk(32'h0050_0000, range_type_pkg::UNCACHEABLE_TYPE);
		lk(32'h0040_0000, range_type_pkg::WRITE_THROUGH_TYPE);
		lk(32'h0070_0000, range_type_pkg::WRITE_BACK_TYPE);
		lk(32'h0100_0000, range_type_pkg::WRITE_COMBINING_TYPE);
		lk(32'h0200_0000, range_type_pkg::WRITE_PROTECTED_TYPE);
		wr(8'h00, 32'h0000_0805);
		lk(32'h0000_0000, range_type_pkg::WRITE_PROTECTED_TYPE);
		qry(32'h004F_F800, 32'h1000, 8'h01, 32'h707, 32'h400);
		qry(32'h0040_0000, 32'h4000, 8'h01, 32'h707, 32'h400);
		qry(32'h004F_F000, 32'h2000, 8'h01, 32'h7, 32'h4);
		qry(32'hFFFF_F000, 32'h2000, 8'h01, 32'h7, 32'h2);
		qry(32'hFFFF_F000, 32'h1000, 8'h01, 32'h707, 32'h500);
		qry(32'h0000_0000, 32'h1000, 8'h22, 32'h7, 32'h3);
		qry(32'h0000_1000, 32'h0000, 8'h12, 32'h7, 32'h2);
		qry(32'h0000_1000, 32'h1000, 8'h42, 32'h7, 32'h0);
		wr(8'h00, 32'h0000_0005);
		qry(32'h0040_0000, 32'h1000, 8'h01, 32'h707, 32'h000);
		lk(32'h0040_0000, range_type_pkg::UNCACHEABLE_TYPE);
		// A second reset in mid-run must clear enables that are set.
		wr(8'h00, 32'h0000_0C05);
		@(posedge sys_clk);
		srst <= 1'b1;
		@(posedge sys_clk);
		srst <= 1'b0;
		rd(8'h11, d); check(d, 32'h0);
		rd(8'h00, d); check(d, 32'h0);
		lk(32'h0060_0000, range_type_pkg::UNCACHEABLE_TYPE);
		conclude();
	end
endmodule : tb_memory_type_range_lookup
